// File: core/ethirq_regs.vh
`ifndef ETHIRQ_REGS_VH
`define ETHIRQ_REGS_VH

`define ETHIRQ_ADDR_W          8
`define ETHIRQ_OFS_IRQ_EN      8'h00
`define ETHIRQ_OFS_IRQ_FLAG    8'h04
`define ETHIRQ_OFS_FLAG_CLR    8'h08
`define ETHIRQ_OFS_CTRL_ONE    8'h0C
`define ETHIRQ_OFS_STATUS      8'h10
`define ETHIRQ_OFS_PHY_EN      8'h14
`define ETHIRQ_OFS_PHY_REQ     8'h18
`define ETHIRQ_OFS_PKT_CNT     8'h1C
`define ETHIRQ_OFS_RX_FILT     8'h20

`define ETHIRQ_BIT_GLOBAL      7
`define ETHIRQ_BIT_PKT         6
`define ETHIRQ_BIT_DMA         5
`define ETHIRQ_BIT_LINK        4
`define ETHIRQ_BIT_TX          3
`define ETHIRQ_BIT_EN_RSVD     2
`define ETHIRQ_BIT_TXERR       1
`define ETHIRQ_BIT_RXERR       0

`define ETHIRQ_BIT_DMA_GO      5
`define ETHIRQ_BIT_TX_REQ      3

`define ETHIRQ_BIT_INT_STAT    7
`define ETHIRQ_BIT_TX_ABORT    1

`define ETHIRQ_BIT_PHY_LINK    4
`define ETHIRQ_BIT_PHY_GLOBAL  2
`define ETHIRQ_BIT_PHY_GEN     1

`define ETHIRQ_BIT_PKT_DEC     0
`define ETHIRQ_BIT_CRC_EN      5
`define ETHIRQ_BIT_WAKE_EN     0

`define ETHIRQ_RST_BYTE        8'h00
`define ETHIRQ_CNT_MAX         8'hFF
`define ETHIRQ_CNT_ONE         8'h01

`endif

// File: core/ethirq_top.v
// Behaviour
// - Request fall sets transmit-done flag
// - Done and link flags sticky until cleared
// - Pin low when flag and enables set
// - Link flag stays clear until enabled
// - Link flag mirrors PHY global flag
// - PHY global flag equals PHY link flag
// - Link interrupt needs all four enables
// - Link flag ignores host writes
// - PHY request read clears link flags
// - DMA go fall sets DMA-done flag
// - Host cancel also sets DMA-done flag
// - Pending flag set while counter nonzero
// - New stored packet drives pin low
// - Counter reaching zero clears pending flag
// - Wake packet counts, flags and interrupts
// - Abort sets done flag same cycle
// - PHY request bits four and two
`timescale 1ns/1ps
`default_nettype none
`include "ethirq_regs.vh"

module ethirq_top
(
    input  wire                      i_ref_clk,
    input  wire                      i_rst_b,
    input  wire [`ETHIRQ_ADDR_W-1:0] i_avs_address,
    input  wire                      i_avs_read,
    input  wire                      i_avs_write,
    input  wire [31:0]               i_avs_writedata,
    input  wire [3:0]                i_avs_byteenable,
    output wire [31:0]               o_avs_readdata,
    output wire                      o_avs_waitrequest,
    input  wire                      i_tx_done,
    input  wire                      i_tx_abort,
    input  wire                      i_dma_done,
    input  wire                      i_link_change,
    input  wire                      i_rx_pkt_stored,
    output wire                      o_tx_request,
    output wire                      o_dma_go,
    output wire                      o_crc_check_en,
    output wire                      o_wake_filter_en,
    output wire                      o_int_n
);

    reg  [7:0]  irq_enable_q;
    reg  [7:0]  irq_enable_d;
    reg         tx_done_flag_q;
    reg         tx_done_flag_d;
    reg         dma_done_flag_q;
    reg         dma_done_flag_d;
    reg         tx_error_flag_q;
    reg         tx_error_flag_d;
    reg         rx_error_flag_q;
    reg         rx_error_flag_d;
    reg         tx_request_q;
    reg         tx_request_d;
    reg         dma_go_q;
    reg         dma_go_d;
    reg         tx_abort_status_q;
    reg         tx_abort_status_d;
    reg         phy_link_irq_en_q;
    reg         phy_link_irq_en_d;
    reg         phy_global_irq_en_q;
    reg         phy_global_irq_en_d;
    reg         phy_link_flag_q;
    reg         phy_link_flag_d;
    reg         phy_global_flag_q;
    reg         phy_global_flag_d;
    reg  [7:0]  rx_packet_counter_q;
    reg  [7:0]  rx_packet_counter_d;
    reg  [7:0]  rx_filter_q;
    reg  [7:0]  rx_filter_d;
    reg         wait_q;
    reg  [31:0] rdata_q;
    reg  [31:0] rdata_d;
    reg         int_n_q;
    reg         int_n_d;
    reg  [7:0]  flag_byte;
    reg  [7:0]  wbyte;
    reg         acc;
    reg         wr;
    reg         rd;
    reg         hit_en;
    reg         hit_clr;
    reg         hit_ctrl;
    reg         hit_stat;
    reg         hit_phy_en;
    reg         hit_phy_req;
    reg         hit_cnt;
    reg         hit_filt;
    reg         abort_ev;
    reg         pkt_inc;
    reg         pkt_dec;
    reg         link_active;
    reg         pkt_pending_flag;
    reg         link_change_flag;
    reg         any_irq;

    assign o_avs_readdata    = rdata_q;
    assign o_avs_waitrequest = wait_q;
    assign o_tx_request      = tx_request_q;
    assign o_dma_go          = dma_go_q;
    assign o_crc_check_en    = rx_filter_q[`ETHIRQ_BIT_CRC_EN];
    assign o_wake_filter_en  = rx_filter_q[`ETHIRQ_BIT_WAKE_EN];
    assign o_int_n           = int_n_q;

    always @*
    begin
        // A request is taken only in the cycle where waitrequest reads low.
        acc         = (i_avs_read | i_avs_write) & ~wait_q;
        wr          = acc & i_avs_write & i_avs_byteenable[0];
        rd          = acc & i_avs_read;
        wbyte       = i_avs_writedata[7:0];
        hit_en      = (i_avs_address == `ETHIRQ_OFS_IRQ_EN);
        hit_clr     = (i_avs_address == `ETHIRQ_OFS_IRQ_FLAG) |
                      (i_avs_address == `ETHIRQ_OFS_FLAG_CLR);
        hit_ctrl    = (i_avs_address == `ETHIRQ_OFS_CTRL_ONE);
        hit_stat    = (i_avs_address == `ETHIRQ_OFS_STATUS);
        hit_phy_en  = (i_avs_address == `ETHIRQ_OFS_PHY_EN);
        hit_phy_req = (i_avs_address == `ETHIRQ_OFS_PHY_REQ);
        hit_cnt     = (i_avs_address == `ETHIRQ_OFS_PKT_CNT);
        hit_filt    = (i_avs_address == `ETHIRQ_OFS_RX_FILT);

        pkt_pending_flag = (rx_packet_counter_q != `ETHIRQ_RST_BYTE);
        link_change_flag = phy_global_flag_q;

        flag_byte = `ETHIRQ_RST_BYTE;
        flag_byte[`ETHIRQ_BIT_PKT]   = pkt_pending_flag;
        flag_byte[`ETHIRQ_BIT_DMA]   = dma_done_flag_q;
        flag_byte[`ETHIRQ_BIT_LINK]  = link_change_flag;
        flag_byte[`ETHIRQ_BIT_TX]    = tx_done_flag_q;
        flag_byte[`ETHIRQ_BIT_TXERR] = tx_error_flag_q;
        flag_byte[`ETHIRQ_BIT_RXERR] = rx_error_flag_q;

        irq_enable_d = irq_enable_q;
        if (wr & hit_en)
        begin
            irq_enable_d = wbyte;
            irq_enable_d[`ETHIRQ_BIT_EN_RSVD] = 1'b0;
        end

        phy_link_irq_en_d   = phy_link_irq_en_q;
        phy_global_irq_en_d = phy_global_irq_en_q;
        if (wr & hit_phy_en)
        begin
            phy_link_irq_en_d   = wbyte[`ETHIRQ_BIT_PHY_LINK];
            phy_global_irq_en_d = wbyte[`ETHIRQ_BIT_PHY_GEN];
        end

        rx_filter_d = rx_filter_q;
        if (wr & hit_filt)
        begin
            rx_filter_d = wbyte;
        end

        // Hardware completion only ends a request that is really running.
        tx_request_d = tx_request_q;
        abort_ev     = i_tx_abort & tx_request_q;
        if (wr & hit_ctrl)
        begin
            tx_request_d = wbyte[`ETHIRQ_BIT_TX_REQ];
        end
        if ((i_tx_done | i_tx_abort) & tx_request_q)
        begin
            tx_request_d = 1'b0;
        end

        dma_go_d = dma_go_q;
        if (wr & hit_ctrl)
        begin
            dma_go_d = wbyte[`ETHIRQ_BIT_DMA_GO];
        end
        if (i_dma_done & dma_go_q)
        begin
            dma_go_d = 1'b0;
        end

        tx_abort_status_d = tx_abort_status_q;
        if (wr & hit_stat & wbyte[`ETHIRQ_BIT_TX_ABORT])
        begin
            tx_abort_status_d = 1'b0;
        end
        if (abort_ev)
        begin
            tx_abort_status_d = 1'b1;
        end

        // Clears come first so that a set in the same cycle wins.
        tx_done_flag_d  = tx_done_flag_q;
        dma_done_flag_d = dma_done_flag_q;
        tx_error_flag_d = tx_error_flag_q;
        rx_error_flag_d = rx_error_flag_q;
        if (wr & hit_clr)
        begin
            tx_done_flag_d  = tx_done_flag_q & ~wbyte[`ETHIRQ_BIT_TX];
            dma_done_flag_d = dma_done_flag_q & ~wbyte[`ETHIRQ_BIT_DMA];
            tx_error_flag_d = tx_error_flag_q & ~wbyte[`ETHIRQ_BIT_TXERR];
            rx_error_flag_d = rx_error_flag_q & ~wbyte[`ETHIRQ_BIT_RXERR];
        end
        if (tx_request_q & ~tx_request_d)
        begin
            tx_done_flag_d = 1'b1;
        end
        if (abort_ev)
        begin
            tx_error_flag_d = 1'b1;
        end
        if (dma_go_q & ~dma_go_d)
        begin
            dma_done_flag_d = 1'b1;
        end

        pkt_inc = i_rx_pkt_stored & (rx_packet_counter_q != `ETHIRQ_CNT_MAX);
        pkt_dec = wr & hit_cnt & wbyte[`ETHIRQ_BIT_PKT_DEC] &
                  (rx_packet_counter_q != `ETHIRQ_RST_BYTE);
        if (i_rx_pkt_stored & ~pkt_inc)
        begin
            rx_error_flag_d = 1'b1;
        end
        rx_packet_counter_d = rx_packet_counter_q;
        if (pkt_inc & ~pkt_dec)
        begin
            rx_packet_counter_d = rx_packet_counter_q + `ETHIRQ_CNT_ONE;
        end
        else if (pkt_dec & ~pkt_inc)
        begin
            rx_packet_counter_d = rx_packet_counter_q - `ETHIRQ_CNT_ONE;
        end

        phy_link_flag_d   = phy_link_flag_q;
        phy_global_flag_d = phy_global_flag_q;
        if (rd & hit_phy_req)
        begin
            phy_link_flag_d   = 1'b0;
            phy_global_flag_d = 1'b0;
        end
        if (i_link_change & phy_link_irq_en_q & phy_global_irq_en_q)
        begin
            phy_link_flag_d   = 1'b1;
            phy_global_flag_d = 1'b1;
        end

        link_active = link_change_flag & irq_enable_q[`ETHIRQ_BIT_LINK] &
                      phy_link_irq_en_q & phy_global_irq_en_q;
        any_irq = irq_enable_q[`ETHIRQ_BIT_GLOBAL] &
                  (link_active |
                   (tx_done_flag_q & irq_enable_q[`ETHIRQ_BIT_TX]) |
                   (dma_done_flag_q & irq_enable_q[`ETHIRQ_BIT_DMA]) |
                   (pkt_pending_flag & irq_enable_q[`ETHIRQ_BIT_PKT]) |
                   (tx_error_flag_q & irq_enable_q[`ETHIRQ_BIT_TXERR]) |
                   (rx_error_flag_q & irq_enable_q[`ETHIRQ_BIT_RXERR]));
        int_n_d = ~any_irq;

        // Read data is latched on the wait cycle, so it stands when taken.
        rdata_d = 32'h0000_0000;
        if (hit_en)
        begin
            rdata_d[7:0] = irq_enable_q;
        end
        else if (hit_clr)
        begin
            rdata_d[7:0] = flag_byte;
        end
        else if (hit_ctrl)
        begin
            rdata_d[`ETHIRQ_BIT_DMA_GO] = dma_go_q;
            rdata_d[`ETHIRQ_BIT_TX_REQ] = tx_request_q;
        end
        else if (hit_stat)
        begin
            rdata_d[`ETHIRQ_BIT_INT_STAT] = ~int_n_q;
            rdata_d[`ETHIRQ_BIT_TX_ABORT] = tx_abort_status_q;
        end
        else if (hit_phy_en)
        begin
            rdata_d[`ETHIRQ_BIT_PHY_LINK] = phy_link_irq_en_q;
            rdata_d[`ETHIRQ_BIT_PHY_GEN]  = phy_global_irq_en_q;
        end
        else if (hit_phy_req)
        begin
            rdata_d[`ETHIRQ_BIT_PHY_LINK]   = phy_link_flag_q;
            rdata_d[`ETHIRQ_BIT_PHY_GLOBAL] = phy_global_flag_q;
        end
        else if (hit_cnt)
        begin
            rdata_d[7:0] = rx_packet_counter_q;
        end
        else if (hit_filt)
        begin
            rdata_d[7:0] = rx_filter_q;
        end
    end

    always @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            irq_enable_q        <= `ETHIRQ_RST_BYTE;
            tx_done_flag_q      <= 1'b0;
            dma_done_flag_q     <= 1'b0;
            tx_error_flag_q     <= 1'b0;
            rx_error_flag_q     <= 1'b0;
            tx_request_q        <= 1'b0;
            dma_go_q            <= 1'b0;
            tx_abort_status_q   <= 1'b0;
            phy_link_irq_en_q   <= 1'b0;
            phy_global_irq_en_q <= 1'b0;
            phy_link_flag_q     <= 1'b0;
            phy_global_flag_q   <= 1'b0;
            rx_packet_counter_q <= `ETHIRQ_RST_BYTE;
            rx_filter_q         <= `ETHIRQ_RST_BYTE;
            wait_q              <= 1'b1;
            rdata_q             <= 32'h0000_0000;
            int_n_q             <= 1'b1;
        end
        else
        begin
            irq_enable_q        <= irq_enable_d;
            tx_done_flag_q      <= tx_done_flag_d;
            dma_done_flag_q     <= dma_done_flag_d;
            tx_error_flag_q     <= tx_error_flag_d;
            rx_error_flag_q     <= rx_error_flag_d;
            tx_request_q        <= tx_request_d;
            dma_go_q            <= dma_go_d;
            tx_abort_status_q   <= tx_abort_status_d;
            phy_link_irq_en_q   <= phy_link_irq_en_d;
            phy_global_irq_en_q <= phy_global_irq_en_d;
            phy_link_flag_q     <= phy_link_flag_d;
            phy_global_flag_q   <= phy_global_flag_d;
            rx_packet_counter_q <= rx_packet_counter_d;
            rx_filter_q         <= rx_filter_d;
            int_n_q             <= int_n_d;
            if ((i_avs_read | i_avs_write) & wait_q)
            begin
                wait_q  <= 1'b0;
                rdata_q <= rdata_d;
            end
            else
            begin
                wait_q <= 1'b1;
            end
        end
    end

endmodule // ethirq_top

`default_nettype wire

// File: tb/ethirq_top_sva.sv
`timescale 1ns/1ps
`default_nettype none
module ethirq_top_sva (
    input wire logic        i_ref_clk,
    input wire logic        i_rst_b,
    input wire logic        i_avs_read,
    input wire logic        i_avs_write,
    input wire logic        i_tx_done,
    input wire logic        i_tx_abort,
    input wire logic        i_dma_done,
    input wire logic        i_link_change,
    input wire logic        i_rx_pkt_stored,
    input wire logic [31:0] o_avs_readdata,
    input wire logic        o_avs_waitrequest,
    input wire logic        o_tx_request,
    input wire logic        o_dma_go,
    input wire logic        o_int_n
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    wire logic req  = i_avs_read || i_avs_write;
    wire logic take = req && !o_avs_waitrequest;
    wire logic hw   = i_tx_done || i_tx_abort;
    wire logic cause = hw || i_dma_done || i_link_change || i_rx_pkt_stored || take;
    sequence s_wait;
        req && o_avs_waitrequest;
    endsequence
    sequence s_take;
        take;
    endsequence
    a_wait_ends: assert property (s_wait |=> !o_avs_waitrequest)
        else $error("waitrequest stayed high");
    a_wait_once: assert property (s_take |=> o_avs_waitrequest)
        else $error("waitrequest low twice");
    a_rdata_high: assert property (o_avs_readdata[31:8] == 24'h00_0000)
        else $error("readdata high bits set");
    a_tx_done_ends: assert property (o_tx_request && hw |=> !o_tx_request)
        else $error("tx request kept after done");
    a_dma_done_ends: assert property (o_dma_go && i_dma_done |=> !o_dma_go)
        else $error("dma go kept after done");
    a_tx_fall_why: assert property ($fell(o_tx_request) |-> $past(hw) || $past(take))
        else $error("tx request fell without cause");
    a_pin_fall_why: assert property ($fell(o_int_n) |-> $past(cause, 2) || $past(cause, 3))
        else $error("pin fell without cause");
    a_pin_rise_why: assert property ($rose(o_int_n) |-> $past(take, 2) || $past(take, 3))
        else $error("pin rose without host access");
endmodule // ethirq_top_sva
bind ethirq_top ethirq_top_sva i_ethirq_top_sva (
    .i_ref_clk, .i_rst_b, .i_avs_read, .i_avs_write, .i_tx_done, .i_tx_abort,
    .i_dma_done, .i_link_change, .i_rx_pkt_stored, .o_avs_readdata,
    .o_avs_waitrequest, .o_tx_request, .o_dma_go, .o_int_n);
`default_nettype wire

// File: tb/ethirq_mac_model.sv
`timescale 1ns/1ps
`default_nettype none
module ethirq_mac_model (
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    input  wire logic [2:0] i_cmd,
    input  wire logic [1:0] i_dly,
    input  wire logic       i_tx_request,
    input  wire logic       i_dma_go,
    output logic      [4:0] o_ev
);
    logic [2:0] cmd_q;
    logic [1:0] cnt_q;
    logic [4:0] ev_q;
    always_ff @(posedge i_ref_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cmd_q <= 3'h0;
            cnt_q <= 2'h0;
            ev_q  <= 5'h00;
        end
        else
        begin
            ev_q <= 5'h00;
            if (i_cmd != 3'h0)
            begin
                cmd_q <= i_cmd;
                cnt_q <= i_dly;
            end
            else if (cnt_q != 2'h0)
                cnt_q <= cnt_q - 2'h1;
            else if (cmd_q != 3'h0)
            begin
                cmd_q <= 3'h0;
                ev_q  <= 5'h01 << (cmd_q - 3'h1);
            end
        end
    end
    // Ends running work. A stale command must never end idle work.
    assign o_ev = i_rst_b ? ev_q & {2'b11, i_dma_go, i_tx_request, i_tx_request} : 5'h00;
endmodule // ethirq_mac_model
`default_nettype wire

// File: tb/ethernet_irq_flag_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ethernet_irq_flag_logic_tb;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic [3:0]  be = 4'h1;
    logic [2:0]  cmd = 3'h0;
    logic [1:0]  dly = 2'h0;
    logic [7:0]  rnd = 8'h56;
    logic [7:0]  fl = 8'h00;
    logic [7:0]  en = 8'h00;
    logic [7:0]  pe = 8'h00;
    logic [31:0] q;
    logic [4:0]  ev;
    wire  [31:0] rdata;
    wire         wreq, txr, dgo, crc, wake, int_n;
    int          bad_count = 0;
    int          checks = 0;
    int          cyc = 0;
    ethirq_top i_ethirq_top (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_tx_done(ev[0]),
        .i_tx_abort(ev[1]), .i_dma_done(ev[2]), .i_link_change(ev[3]),
        .i_rx_pkt_stored(ev[4]), .o_tx_request(txr), .o_dma_go(dgo),
        .o_crc_check_en(crc), .o_wake_filter_en(wake), .o_int_n(int_n));
    ethirq_mac_model i_ethirq_mac_model (
        .i_ref_clk(clk), .i_rst_b(rst_b), .i_cmd(cmd), .i_dly(dly),
        .i_tx_request(txr), .i_dma_go(dgo), .o_ev(ev));
    initial forever #2 clk = ~clk;
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic pin_exp(input logic [7:0] f, input logic [7:0] e,
                                     input logic [7:0] p);
        logic [7:0] m;
        m = f & e & 8'h7B;
        // The link source also needs both PHY enables.
        if (!(p[4] && p[1]))
            m[4] = 1'b0;
        return !(e[7] && |m);
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        wd <= {24'h00_0000, d};
        do @(posedge clk); while (wreq !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e, input string nm);
        bus(1'b0, a, 8'h00);
        chk(q, {24'h00_0000, e}, nm);
    endtask
    task automatic flchk;
        rdchk(8'h04, fl, "flags");
        @(negedge clk);
        chk({31'h0, int_n}, {31'h0, pin_exp(fl, en, pe)}, "int_n");
    endtask
    task automatic fire(input logic [2:0] c);
        @(posedge clk);
        cmd <= c;
        dly <= rnd[1:0];
        rnd = lfsr(rnd);
        @(posedge clk);
        cmd <= 3'h0;
        repeat (8) @(posedge clk);
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            bad_count++;
            close_out();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        flchk();
        rdchk(8'h24, 8'h00, "unmapped");
        en = 8'h88;
        bus(1'b1, 8'h00, en);
        bus(1'b1, 8'h0C, 8'h08);
        @(negedge clk);
        chk({31'h0, txr}, 32'h0000_0001, "tx_request");
        fire(3'h1);
        fl = 8'h08;
        flchk();
        chk({31'h0, txr}, 32'h0000_0000, "tx_request");
        bus(1'b1, 8'h04, 8'h00);
        be <= 4'h0;
        bus(1'b1, 8'h04, 8'h08);
        be <= 4'h1;
        flchk();
        bus(1'b1, 8'h08, 8'h08);
        fl = 8'h00;
        flchk();
        bus(1'b1, 8'h0C, 8'h08);
        fire(3'h2);
        fl = 8'h0A;
        flchk();
        rdchk(8'h10, 8'h82, "status");
        bus(1'b1, 8'h10, 8'h02);
        bus(1'b1, 8'h04, 8'h0A);
        bus(1'b1, 8'h0C, 8'h08);
        bus(1'b1, 8'h0C, 8'h00);
        bus(1'b1, 8'h0C, 8'h20);
        rdchk(8'h0C, 8'h20, "ctrl");
        @(negedge clk);
        chk({31'h0, dgo}, 32'h0000_0001, "dma_go");
        fire(3'h3);
        fl = 8'h28;
        flchk();
        chk({31'h0, dgo}, 32'h0000_0000, "dma_go");
        bus(1'b1, 8'h04, 8'h28);
        bus(1'b1, 8'h0C, 8'h20);
        bus(1'b1, 8'h0C, 8'h00);
        fl = 8'h20;
        flchk();
        rdchk(8'h0C, 8'h00, "ctrl");
        for (int i = 0; i < 6; i++)
        begin
            en = rnd & 8'hFB;
            bus(1'b1, 8'h00, rnd);
            rnd = lfsr(rnd);
            rdchk(8'h00, en, "irq_en");
            flchk();
        end
        bus(1'b1, 8'h04, 8'h20);
        en = 8'h90;
        bus(1'b1, 8'h00, en);
        fire(3'h4);
        fl = 8'h00;
        flchk();
        pe = 8'h12;
        bus(1'b1, 8'h14, pe);
        fire(3'h4);
        bus(1'b1, 8'h04, 8'h10);
        fl = 8'h10;
        flchk();
        pe = 8'h02;
        bus(1'b1, 8'h14, pe);
        rdchk(8'h14, pe, "phy_en");
        flchk();
        rdchk(8'h18, 8'h14, "phy_req");
        fl = 8'h00;
        flchk();
        rdchk(8'h18, 8'h00, "phy_req");
        en = 8'hC0;
        bus(1'b1, 8'h00, en);
        repeat (3) fire(3'h5);
        fl = 8'h40;
        flchk();
        rdchk(8'h1C, 8'h03, "pkt_cnt");
        repeat (4) bus(1'b1, 8'h1C, 8'h01);
        fl = 8'h00;
        flchk();
        rdchk(8'h1C, 8'h00, "pkt_cnt");
        bus(1'b1, 8'h20, 8'h21);
        @(negedge clk);
        chk({30'h0, crc, wake}, 32'h0000_0003, "filters");
        fire(3'h5);
        fl = 8'h40;
        flchk();
        rdchk(8'h10, 8'h80, "status");
        rdchk(8'h1C, 8'h01, "pkt_cnt");
        repeat (255) fire(3'h5);
        fl = 8'h41;
        flchk();
        rdchk(8'h1C, 8'hFF, "pkt_cnt");
        close_out();
    end
endmodule // ethernet_irq_flag_logic_tb
`default_nettype wire
